// ### rtl/dtm_defines.vh
`ifndef DTM_DEFINES_VH
`define DTM_DEFINES_VH

// register indices; byte address is four times the index
`define DTM_OFF_EVENT_FLAGS   4'h0
`define DTM_OFF_SMI_ROUTING   4'h2
`define DTM_OFF_IRQ_ROUTING   4'h4
`define DTM_OFF_SENSOR_CFG    4'h8
`define DTM_OFF_BANK_SEL      4'h9
`define DTM_OFF_CH_CFG_STS    4'ha
`define DTM_OFF_CH_READING    4'hb
`define DTM_OFF_CH_HIGH       4'hc
`define DTM_OFF_CH_LOW        4'hd
`define DTM_OFF_CH_OVERTEMP   4'he

// channel configuration and status bits
`define DTM_CS_EOC            7
`define DTM_CS_OPEN           6
`define DTM_CS_OTS_EN         5
`define DTM_CS_ALERT_EN       4
`define DTM_CS_OT_EXC         3
`define DTM_CS_HI_EXC         2
`define DTM_CS_LO_EXC         1
`define DTM_CS_CH_EN          0
`define DTM_CS_RW_MASK        8'h31
`define DTM_CS_W1C_MASK       8'h0e
`define DTM_CS_RST            8'h00

// sensor configuration bits
`define DTM_CFG_STANDBY       0
`define DTM_CFG_RW_MASK       8'h03
`define DTM_CFG_RST           8'h03

// event flags and routing enables
`define DTM_EVENT_MASK        8'h3f
`define DTM_EVENT_RST         8'h00
`define DTM_ROUTE_RST         8'h00
`define DTM_BANK_RST          4'h0
`define DTM_BANK_MAX          4'h2
`define DTM_ALARM_IDLE        3'h7

// temperature values, two's complement, one degree per step
`define DTM_TEMP_ZERO         8'h00
`define DTM_TEMP_127          8'h7f
`define DTM_TEMP_MINUS_55     8'hc9

`endif

// ### rtl/dtm_monitor.v
// Contract
// - reading holds latest conversion result
// - event flags latched until software clears
// - readings start at zero degrees
// - status and command registers reset to zero, sensor configuration to 03
// - limits reset 127, 127, minus 55
// - all temperatures signed bytes, one degree
// - standby bit set stops conversions
// - registers stay accessible during standby
// - fault check runs before each conversion
// - open diode reports 127, raises both outputs
// - shorted diode reports zero, no low flag
// - write one clears, zero keeps
// - common registers at fixed offsets
// - per-channel registers at fixed offsets
// - event flag bit positions per channel
// - event flags reset to zero
// - smi enables per flag, reset disabled
// - interrupt outputs from flags and enables
// - event flags follow channel limit bits
// - limit violations latch own status bits
// - three banks share window, bank zero default
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "dtm_defines.vh"

module dtm_monitor (
	// clock and reset
	input  wire        clock_i,
	input  wire        rst_i,
	// avalon-mm register slave
	input  wire [5:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	// converter handshake
	output reg         conv_start_o,
	output reg  [1:0]  conv_channel_o,
	input  wire        conv_done_i,
	input  wire [7:0]  conv_value_i,
	// diode fault comparators, asynchronous
	input  wire [2:0]  diode_anode_open_i,
	input  wire [2:0]  diode_anode_short_i,
	// alarm and interrupt outputs
	output reg  [2:0]  alert_n_o,
	output reg  [2:0]  overtemp_shutdown_out_n_o,
	output reg         irq_o,
	output reg         system_mgmt_interrupt_n_o
);

	localparam [1:0] ST_IDLE  = 2'b00;
	localparam [1:0] ST_CHECK = 2'b01;
	localparam [1:0] ST_CONV  = 2'b10;
	localparam [1:0] CH_LAST  = 2'b10;

	// register file
	reg  [7:0] event_flags;
	reg  [7:0] smi_routing_enables;
	reg  [7:0] irq_routing_enables;
	reg  [7:0] sensor_configuration;
	reg  [3:0] bank_selector;
	reg  [7:0] channel_config_status  [0:2];
	reg  [7:0] channel_reading        [0:2];
	reg  [7:0] channel_high_limit     [0:2];
	reg  [7:0] channel_low_limit      [0:2];
	reg  [7:0] channel_overtemp_limit [0:2];

	// fault input synchronisers
	reg  [5:0] fault_s1;
	reg  [5:0] fault_s2;
	reg  [5:0] fault_s3;
	reg  [5:0] fault_filt;

	// sequencer
	reg  [1:0] state;
	reg  [1:0] cur;
	reg        flt_open;
	reg        flt_short;
	reg  [7:0] next_value;
	reg        next_ot;
	reg        next_hi;
	reg        next_lo;

	// bus decode
	wire [3:0] reg_idx  = avs_address_i[5:2];
	wire       wr_go    = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
	wire [7:0] wbyte    = avs_writedata_i[7:0];
	wire       bank_ok  = (bank_selector <= `DTM_BANK_MAX);
	wire [1:0] bank_ch  = bank_selector[1:0];
	wire       conv_end = (state == ST_CONV) & conv_done_i;
	reg  [7:0] next_readdata;
	wire [7:0] next_events;
	integer    i;
	integer    out_ch;
	genvar     g;

	// three-stage pin synchroniser; a change counts once stages two and three agree
	always @(posedge clock_i) begin
		if (rst_i) begin
			fault_s1   <= 6'h00;
			fault_s2   <= 6'h00;
			fault_s3   <= 6'h00;
			fault_filt <= 6'h00;
		end else begin
			fault_s1   <= {diode_anode_short_i, diode_anode_open_i};
			fault_s2   <= fault_s1;
			fault_s3   <= fault_s2;
			fault_filt <= (fault_s2 & fault_s3) | (fault_filt & (fault_s2 | fault_s3));
		end
	end

	// result of the conversion that is ending, with fault overrides
	always @* begin
		if (flt_open) begin
			next_value = `DTM_TEMP_127;
		end else if (flt_short) begin
			next_value = `DTM_TEMP_ZERO;
		end else begin
			next_value = conv_value_i;
		end
		// signed compares against the channel's limits
		next_ot = ($signed(next_value) > $signed(channel_overtemp_limit[cur])) | flt_open;
		next_hi = ($signed(next_value) > $signed(channel_high_limit[cur])) | flt_open;
		next_lo = ($signed(next_value) < $signed(channel_low_limit[cur])) & ~flt_short;
	end

	// conversion sequencer: round robin over enabled channels
	always @(posedge clock_i) begin
		if (rst_i) begin
			state          <= ST_IDLE;
			cur            <= 2'b00;
			flt_open       <= 1'b0;
			flt_short      <= 1'b0;
			conv_start_o   <= 1'b0;
			conv_channel_o <= 2'b00;
		end else begin
			conv_start_o <= 1'b0;
			case (state)
				ST_IDLE: begin
					// standby starts no new conversion
					if (!sensor_configuration[`DTM_CFG_STANDBY]) begin
						if (channel_config_status[cur][`DTM_CS_CH_EN]) begin
							state <= ST_CHECK;
						end else begin
							cur <= (cur == CH_LAST) ? 2'b00 : cur + 2'b01;
						end
					end
				end
				ST_CHECK: begin
					// fault check ahead of the conversion
					flt_open       <= fault_filt[cur];
					flt_short      <= fault_filt[3 + cur] & ~fault_filt[cur];
					conv_start_o   <= 1'b1;
					conv_channel_o <= cur;
					state          <= ST_CONV;
				end
				ST_CONV: begin
					if (conv_done_i) begin
						state <= ST_IDLE;
						cur   <= (cur == CH_LAST) ? 2'b00 : cur + 2'b01;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// common registers
	always @(posedge clock_i) begin
		if (rst_i) begin
			smi_routing_enables  <= `DTM_ROUTE_RST;
			irq_routing_enables  <= `DTM_ROUTE_RST;
			sensor_configuration <= `DTM_CFG_RST;
			bank_selector        <= `DTM_BANK_RST;
		end else if (wr_go) begin
			// writes land whether or not standby is set
			case (reg_idx)
				`DTM_OFF_SMI_ROUTING: smi_routing_enables  <= wbyte & `DTM_EVENT_MASK;
				`DTM_OFF_IRQ_ROUTING: irq_routing_enables  <= wbyte & `DTM_EVENT_MASK;
				`DTM_OFF_SENSOR_CFG:  sensor_configuration <= wbyte & `DTM_CFG_RW_MASK;
				`DTM_OFF_BANK_SEL:    bank_selector        <= wbyte[3:0];
				default: begin
				end
			endcase
		end
	end

	// per-channel registers
	always @(posedge clock_i) begin
		if (rst_i) begin
			for (i = 0; i < 3; i = i + 1) begin
				channel_config_status[i]  <= `DTM_CS_RST;
				channel_reading[i]        <= `DTM_TEMP_ZERO;
				channel_high_limit[i]     <= `DTM_TEMP_127;
				channel_low_limit[i]      <= `DTM_TEMP_MINUS_55;
				channel_overtemp_limit[i] <= `DTM_TEMP_127;
			end
		end else begin
			for (i = 0; i < 3; i = i + 1) begin
				// software writes to the selected bank
				if (wr_go && bank_ok && bank_ch == i[1:0]) begin
					case (reg_idx)
						`DTM_OFF_CH_CFG_STS: begin
							// write one clears the limit bits
							channel_config_status[i] <=
								(channel_config_status[i] & ~`DTM_CS_RW_MASK
								 & ~(wbyte & `DTM_CS_W1C_MASK))
								| (wbyte & `DTM_CS_RW_MASK);
						end
						`DTM_OFF_CH_HIGH:     channel_high_limit[i]     <= wbyte;
						`DTM_OFF_CH_LOW:      channel_low_limit[i]      <= wbyte;
						`DTM_OFF_CH_OVERTEMP: channel_overtemp_limit[i] <= wbyte;
						default: begin
						end
					endcase
				end
				if (state == ST_CHECK && cur == i[1:0]) begin
					channel_config_status[i][`DTM_CS_EOC] <= 1'b0;
				end
				// a completed conversion wins over a same-cycle clear
				if (conv_end && cur == i[1:0]) begin
					channel_reading[i] <= next_value;
					channel_config_status[i][`DTM_CS_EOC]  <= 1'b1;
					channel_config_status[i][`DTM_CS_OPEN] <= flt_open;
					if (next_ot) begin
						channel_config_status[i][`DTM_CS_OT_EXC] <= 1'b1;
					end
					if (next_hi) begin
						channel_config_status[i][`DTM_CS_HI_EXC] <= 1'b1;
					end
					if (next_lo) begin
						channel_config_status[i][`DTM_CS_LO_EXC] <= 1'b1;
					end
				end
			end
		end
	end

	// event flags mirror latched limit bits; cleared only by clearing those
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_event
			assign next_events[2 * g]     = channel_config_status[g][`DTM_CS_HI_EXC]
			                                | channel_config_status[g][`DTM_CS_LO_EXC];
			assign next_events[2 * g + 1] = channel_config_status[g][`DTM_CS_OT_EXC];
		end
	endgenerate

	// reserved flag bits read zero
	assign next_events[7:6] = 2'b00;

	always @(posedge clock_i) begin
		if (rst_i) begin
			event_flags <= `DTM_EVENT_RST;
		end else begin
			event_flags <= next_events;
		end
	end

	// outputs
	always @(posedge clock_i) begin
		if (rst_i) begin
			alert_n_o                 <= `DTM_ALARM_IDLE;
			overtemp_shutdown_out_n_o <= `DTM_ALARM_IDLE;
			irq_o                     <= 1'b0;
			system_mgmt_interrupt_n_o <= 1'b1;
		end else begin
			for (out_ch = 0; out_ch < 3; out_ch = out_ch + 1) begin
				alert_n_o[out_ch] <= ~(channel_config_status[out_ch][`DTM_CS_ALERT_EN]
				                       & next_events[2 * out_ch]);
				overtemp_shutdown_out_n_o[out_ch] <= ~(channel_config_status[out_ch][`DTM_CS_OTS_EN]
				                                       & next_events[2 * out_ch + 1]);
			end
			irq_o                     <= |(event_flags & irq_routing_enables);
			system_mgmt_interrupt_n_o <= ~(|(event_flags & smi_routing_enables));
		end
	end

	// read data selection
	always @* begin
		next_readdata = 8'h00;
		case (reg_idx)
			`DTM_OFF_EVENT_FLAGS: next_readdata = event_flags;
			`DTM_OFF_SMI_ROUTING: next_readdata = smi_routing_enables;
			`DTM_OFF_IRQ_ROUTING: next_readdata = irq_routing_enables;
			`DTM_OFF_SENSOR_CFG:  next_readdata = sensor_configuration;
			`DTM_OFF_BANK_SEL:    next_readdata = {4'h0, bank_selector};
			`DTM_OFF_CH_CFG_STS:  next_readdata = bank_ok ? channel_config_status[bank_ch] : 8'h00;
			`DTM_OFF_CH_READING:  next_readdata = bank_ok ? channel_reading[bank_ch] : 8'h00;
			`DTM_OFF_CH_HIGH:     next_readdata = bank_ok ? channel_high_limit[bank_ch] : 8'h00;
			`DTM_OFF_CH_LOW:      next_readdata = bank_ok ? channel_low_limit[bank_ch] : 8'h00;
			`DTM_OFF_CH_OVERTEMP: next_readdata = bank_ok ? channel_overtemp_limit[bank_ch] : 8'h00;
			default:              next_readdata = 8'h00;
		endcase
	end

	// bus handshake: waitrequest drops for exactly the accepting cycle
	always @(posedge clock_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
		end else begin
			if (!avs_waitrequest_o) begin
				avs_waitrequest_o <= 1'b1;
			end else if (avs_read_i || avs_write_i) begin
				avs_waitrequest_o <= 1'b0;
				// read data stand until the next accepted read
				if (avs_read_i) begin
					avs_readdata_o <= {24'h000000, next_readdata};
				end
			end
		end
	end

endmodule

// ### verification/dtm_monitor_sva.sv
`timescale 1ns/10ps
module dtm_monitor_chk (
	// bus
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// converter and outputs
	input wire logic        conv_start_o,
	input wire logic [1:0]  conv_channel_o,
	input wire logic        conv_done_i,
	input wire logic [2:0]  alert_n_o,
	input wire logic [2:0]  overtemp_shutdown_out_n_o,
	input wire logic        irq_o,
	input wire logic        system_mgmt_interrupt_n_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_req_seen;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_start_wait;
		conv_start_o ##1 !conv_done_i;
	endsequence
	AST_WAIT_ANSWER: assert property (s_req_seen |=> !avs_waitrequest_o)
		else $error("request not answered after one wait cycle");
	AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	AST_WAIT_CAUSE: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
		else $error("waitrequest low without a request");
	AST_RDATA_UPPER: assert property (avs_readdata_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_RDATA_HOLD: assert property ($changed(avs_readdata_o) |-> !avs_waitrequest_o && $past(avs_read_i))
		else $error("read data changed outside a read");
	AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
		else $error("start pulse longer than one cycle");
	AST_START_SPACING: assert property (s_start_wait |=> !conv_start_o)
		else $error("new start while conversion pending");
	AST_CHAN_HOLD: assert property (!conv_start_o |-> $stable(conv_channel_o))
		else $error("channel changed without start");
	AST_RESET_IDLE: assert property ($fell(rst_i) |-> avs_waitrequest_o && !irq_o
		&& !conv_start_o && system_mgmt_interrupt_n_o
		&& (alert_n_o & overtemp_shutdown_out_n_o) == 3'h7)
		else $error("outputs not idle after reset");
endmodule
bind dtm_monitor dtm_monitor_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .conv_start_o(conv_start_o),
	.conv_channel_o(conv_channel_o), .conv_done_i(conv_done_i), .alert_n_o(alert_n_o),
	.overtemp_shutdown_out_n_o(overtemp_shutdown_out_n_o), .irq_o(irq_o),
	.system_mgmt_interrupt_n_o(system_mgmt_interrupt_n_o));

// ### verification/dtm_conv_model.sv
`timescale 1ns/10ps
module dtm_conv_model (
	// converter side
	input  wire logic        clock_i,
	input  wire logic        start_i,
	input  wire logic [1:0]  channel_i,
	input  wire logic [3:0]  lat_i,
	input  wire logic [23:0] temps_i,
	output logic             done_o,
	output logic [7:0]       value_o
);
	logic [3:0] cnt;
	logic [1:0] ch;
	initial begin
		done_o = 1'b0;
		value_o = 8'ha5;
		cnt = 4'h0;
		ch = 2'h0;
	end
	// value toggles outside the done cycle
	always @(posedge clock_i) begin
		done_o <= 1'b0;
		value_o <= ~value_o;
		if (start_i) begin
			cnt <= lat_i;
			ch <= channel_i;
		end else if (cnt == 4'h1) begin
			done_o <= 1'b1;
			value_o <= temps_i[ch*8 +: 8];
			cnt <= 4'h0;
		end else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
endmodule

// ### verification/test_diode_temp_monitor_events.sv
`timescale 1ns/10ps
module test_diode_temp_monitor_events;
	logic        clock_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [5:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic        conv_start_o, conv_done_i, irq_o, system_mgmt_interrupt_n_o;
	logic [1:0]  conv_channel_o;
	logic [7:0]  conv_value_i;
	logic [2:0]  open_i, short_i, alert_n_o, ots_n_o;
	logic [3:0]  lat;
	integer      errors = 0, check_count = 0, starts = 0;
	dtm_monitor u_dut (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .conv_start_o(conv_start_o),
		.conv_channel_o(conv_channel_o), .conv_done_i(conv_done_i), .conv_value_i(conv_value_i),
		.diode_anode_open_i(open_i), .diode_anode_short_i(short_i), .alert_n_o(alert_n_o),
		.overtemp_shutdown_out_n_o(ots_n_o), .irq_o(irq_o),
		.system_mgmt_interrupt_n_o(system_mgmt_interrupt_n_o));
	dtm_conv_model u_conv (.clock_i(clock_i), .start_i(conv_start_o), .channel_i(conv_channel_o),
		.lat_i(lat), .temps_i(24'h059090), .done_o(conv_done_i), .value_o(conv_value_i));
	always @(posedge clock_i) if (conv_start_o === 1'b1) starts++;
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		avs_address_i <= {a, 2'b00};
		avs_writedata_i <= {24'h0, d};
		avs_write_i <= w;
		avs_read_i <= ~w;
		@(posedge clock_i);
		while (avs_waitrequest_o !== 1'b0) begin
			@(posedge clock_i);
		end
		q = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(e, q);
	endtask
	task automatic t_reset;
		rc(4'h9, 8'h00);
		rc(4'h0, 8'h00);
		rc(4'h2, 8'h00);
		rc(4'h4, 8'h00);
		rc(4'h8, 8'h03);
		for (int b = 0; b < 3; b++) begin
			wr(4'h9, b[7:0]);
			rc(4'ha, 8'h00);
			rc(4'hb, 8'h00);
			rc(4'hc, 8'h7f);
			rc(4'hd, 8'hc9);
			rc(4'he, 8'h7f);
		end
	endtask
	task automatic t_rsvd;
		logic [3:0] r[6] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'hf};
		foreach (r[i]) begin
			wr(r[i], 8'hff);
			rc(r[i], 8'h00);
		end
		wr(4'h0, 8'hff);
		rc(4'h0, 8'h00);
		wr(4'h9, 8'h03);
		wr(4'ha, 8'h31);
		rc(4'ha, 8'h00);
	endtask
	task automatic t_standby;
		for (int b = 0; b < 3; b++) begin
			wr(4'h9, b[7:0]);
			wr(4'ha, 8'h31);
			rc(4'ha, 8'h31);
		end
		wr(4'hd, 8'h10);
		rc(4'hd, 8'h10);
		repeat (30) @(posedge clock_i);
		chk(8'h00, starts[7:0]);
	endtask
	task automatic t_conv;
		logic [7:0] er[3] = '{8'h90, 8'h7f, 8'h00};
		logic [7:0] es[3] = '{8'hb3, 8'hfd, 8'hb1};
		wr(4'h8, 8'h02);
		repeat (80) @(posedge clock_i);
		lat <= 4'h9;
		repeat (120) @(posedge clock_i);
		wr(4'h8, 8'h03);
		repeat (30) @(posedge clock_i);
		chk(8'h01, {7'h0, starts > 3});
		for (int b = 0; b < 3; b++) begin
			wr(4'h9, b[7:0]);
			rc(4'hb, er[b]);
			rc(4'ha, es[b]);
		end
		rc(4'h0, 8'h0d);
		chk(8'h04, {5'h0, alert_n_o});
		chk(8'h05, {5'h0, ots_n_o});
		chk(8'h01, {7'h0, system_mgmt_interrupt_n_o});
		wr(4'h4, 8'h08);
		wr(4'h2, 8'h01);
		repeat (3) @(posedge clock_i);
		chk(8'h01, {7'h0, irq_o});
		chk(8'h00, {7'h0, system_mgmt_interrupt_n_o});
		repeat (50) @(posedge clock_i);
		rc(4'h0, 8'h0d);
	endtask
	task automatic t_clear;
		rc(4'h0, 8'h0d);
		wr(4'h9, 8'h00);
		wr(4'ha, 8'h31);
		rc(4'ha, 8'hb3);
		wr(4'ha, 8'h33);
		rc(4'ha, 8'hb1);
		rc(4'h0, 8'h0c);
		repeat (3) @(posedge clock_i);
		chk(8'h01, {7'h0, system_mgmt_interrupt_n_o});
		chk(8'h05, {5'h0, alert_n_o});
		wr(4'h9, 8'h01);
		wr(4'ha, 8'h3d);
		rc(4'ha, 8'hf1);
		rc(4'h0, 8'h00);
		repeat (3) @(posedge clock_i);
		chk(8'h00, {7'h0, irq_o});
		chk(8'h07, {5'h0, ots_n_o});
	endtask
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	initial begin
		#100000;
		errors++;
		finish_test;
	end
	initial begin
		rst_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 6'h00;
		avs_writedata_i = 32'h0;
		open_i = 3'b010;
		short_i = 3'b100;
		lat = 4'h1;
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		t_reset;
		t_rsvd;
		t_standby;
		t_conv;
		t_clear;
		finish_test;
	end
endmodule
